/* File: hdl/dacc_pkg.sv */
// Constants for the dual action capture/compare block
// Operation
// - Force B write of one acts like a B match in output modes.
// - Force B is ignored in disabled and input modes.
// - Force B clears on reset and always reads zero.
// - Force A and force B together clear the output flip-flop.
// - Pulse-width mode: polarity 0 A rises, B falls; polarity 1 swapped.
// - Period and capture modes: A on rising, or falling if polarity 1.
// - Output modes: polarity 0 A match drives 1, B drives 0; else reversed.
// - Edge polarity has no effect in disabled mode.
// - Mode 0000 disabled; 0001 pulse width, 0010 period, 0011 capture.
// - 0100 compare flag on B, 0101 flag on A or B, 1000 PWM.
// - Modes 1001..1111 are PWM at reduced resolution, upper bits ignored.
// - Channel A value is read/write in disabled mode for preloading.
// - Pulse-width mode: A holds time base at leading pulse edge.
// - Period and capture modes: A holds time base at latest edge.
// - Compare modes: writing A arms its comparator until next match.
// - PWM mode: A value gives the leading edge of each pulse.
// - Event flag set per mode: captures, B, A-or-B, or A matches.
// - Force A write of one acts like an A match in output modes.
// - Time base select picks bus A at 0, bus B at 1.
// - Compare modes: writing B arms its comparator until next match.
package dacc_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] DACC_OFS_CTRL = 8'h00;
   localparam logic [7:0] DACC_OFS_CHA = 8'h04;
   localparam logic [7:0] DACC_OFS_CHB = 8'h08;

   // ==========================================================
   // Control/status field positions
   localparam int DACC_BIT_FLAG = 15;
   localparam int DACC_BIT_WOR = 9;
   localparam int DACC_BIT_TBSEL = 8;
   localparam int DACC_BIT_PIN = 7;
   localparam int DACC_BIT_FORCE_COMPARE_A = 6;
   localparam int DACC_BIT_FORCE_COMPARE_B = 5;
   localparam int DACC_BIT_EDGE_POLARITY = 4;

   // ==========================================================
   // Mode codes
   localparam logic [3:0] DACC_MODE_OFF = 4'h0;
   localparam logic [3:0] DACC_MODE_PWIN = 4'h1;
   localparam logic [3:0] DACC_MODE_PERIOD = 4'h2;
   localparam logic [3:0] DACC_MODE_CAPT = 4'h3;
   localparam logic [3:0] DACC_MODE_OCB = 4'h4;
   localparam logic [3:0] DACC_MODE_COMPARE_FLAG_BOTH_MODE = 4'h5;
   localparam logic [3:0] DACC_MODE_PWM16 = 4'h8;

   // ==========================================================
   // Reset values
   localparam logic [15:0] DACC_RST_VALUE = 16'h0000;
   localparam logic [3:0] DACC_RST_MODE = 4'h0;

   // Decoded operating class of a mode code
   typedef enum {
      DACC_OP_OFF,
      DACC_OP_PWIN,
      DACC_OP_PERIOD,
      DACC_OP_CAPT,
      DACC_OP_OCB,
      DACC_OP_COMPARE_FLAG_BOTH_MODE,
      DACC_OP_PWM
   } dacc_op_e;

endpackage

/* File: hdl/dacc_edge.sv */
// Pin edge detector feeding the capture channels
`timescale 1ns/1ps
`default_nettype none
module dacc_edge (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_in,
   output logic level,
   output logic rise,
   output logic fall
);
   logic prev_q;
   logic prev_d;

   // Next previous sample
   always_comb begin
      prev_d = pin_in;
   end

   // Sample the pin once per clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end

   // Edges compare the live pin with last cycle's level
   assign level = pin_in;
   assign rise = pin_in & ~prev_q;
   assign fall = ~pin_in & prev_q;
endmodule // dacc_edge
`default_nettype wire

/* File: hdl/dacc_top.sv */
// Dual action capture/compare channel pair with APB register access
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dacc_top
   import dacc_pkg::*;
#(
   parameter int TB_WIDTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [TB_WIDTH-1:0] time_base_a,
   input wire logic [TB_WIDTH-1:0] time_base_b,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe_n
);

   // ==========================================================
   // Helper functions

   // Operating class of a mode code; unused codes fall to off
   function automatic dacc_op_e op_of(input logic [3:0] m);
      dacc_op_e r;
      r = DACC_OP_OFF;
      case (m)
         DACC_MODE_PWIN: r = DACC_OP_PWIN;
         DACC_MODE_PERIOD: r = DACC_OP_PERIOD;
         DACC_MODE_CAPT: r = DACC_OP_CAPT;
         DACC_MODE_OCB: r = DACC_OP_OCB;
         DACC_MODE_COMPARE_FLAG_BOTH_MODE: r = DACC_OP_COMPARE_FLAG_BOTH_MODE;
         default: begin
            if (m[3]) begin
               r = DACC_OP_PWM;
            end else begin
               r = DACC_OP_OFF;
            end
         end
      endcase
      return r;
   endfunction

   // Mask of time base bits that take part in a compare
   function automatic logic [TB_WIDTH-1:0] res_mask(input logic [3:0] m);
      logic [TB_WIDTH-1:0] r;
      r = '1;
      case (m)
         4'h9: r = TB_WIDTH'(16'h7FFF);
         4'hA: r = TB_WIDTH'(16'h3FFF);
         4'hB: r = TB_WIDTH'(16'h1FFF);
         4'hC: r = TB_WIDTH'(16'h0FFF);
         4'hD: r = TB_WIDTH'(16'h07FF);
         4'hE: r = TB_WIDTH'(16'h01FF);
         4'hF: r = TB_WIDTH'(16'h007F);
         default: r = '1;
      endcase
      return r;
   endfunction

   // ==========================================================
   // State
   logic [3:0] mode_q, mode_d;
   logic edge_polarity_q, edge_polarity_d;
   logic tbsel_q, tbsel_d;
   logic wor_q, wor_d;
   logic flag_q, flag_d;
   logic flag_seen_q, flag_seen_d;
   logic [TB_WIDTH-1:0] cha_q, cha_d;
   logic [TB_WIDTH-1:0] chb1_q, chb1_d;
   logic [TB_WIDTH-1:0] chb2_q, chb2_d;
   logic arm_a_q, arm_a_d;
   logic arm_b_q, arm_b_d;
   logic first_q, first_d;
   logic ff_q, ff_d;
   logic pin_out_q, pin_out_d;
   logic oe_n_q, oe_n_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;

   logic pin_lvl, pin_rise, pin_fall;
   dacc_op_e op;
   logic out_mode;
   logic [TB_WIDTH-1:0] tb, msk;
   logic edge_a, edge_b, match_a, match_b;
   logic acc, wr, rd, hit_ctrl, hit_a, hit_b;

   dacc_edge u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(pin_in),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // ==========================================================
   // Decode of mode, time base, edges and compares
   always_comb begin
      op = op_of(mode_q);
      out_mode = (op == DACC_OP_OCB) || (op == DACC_OP_COMPARE_FLAG_BOTH_MODE) ||
                 (op == DACC_OP_PWM);
      tb = tbsel_q ? time_base_b : time_base_a;
      msk = res_mask(mode_q);
      // Channel A edge: rising at polarity 0, falling at 1
      edge_a = edge_polarity_q ? pin_fall : pin_rise;
      edge_b = edge_polarity_q ? pin_rise : pin_fall;
      // Single-shot compares need arming; PWM compares every period
      match_a = ((tb & msk) == (cha_q & msk)) &&
                (arm_a_q || op == DACC_OP_PWM);
      match_b = ((tb & msk) == (chb2_q & msk)) &&
                (arm_b_q || op == DACC_OP_PWM);
   end

   // ==========================================================
   // APB decode; zero wait states, ready comes from a flop
   always_comb begin
      acc = psel && penable && pready_q;
      wr = acc && pwrite;
      rd = acc && !pwrite;
      hit_ctrl = (paddr == DACC_OFS_CTRL);
      hit_a = (paddr == DACC_OFS_CHA);
      hit_b = (paddr == DACC_OFS_CHB);
   end

   // Bus answer: ready in the first access cycle, read data staged
   always_comb begin
      pready_d = psel && !penable && !pready_q;
      pslverr_d = psel && !penable && !(hit_ctrl || hit_a || hit_b);
      prdata_d = 32'h0000_0000;
      if (psel && !penable) begin
         if (hit_ctrl) begin
            prdata_d[DACC_BIT_FLAG] = flag_q;
            prdata_d[DACC_BIT_WOR] = wor_q;
            prdata_d[DACC_BIT_TBSEL] = tbsel_q;
            // Pin level in input modes, driven level in output modes
            prdata_d[DACC_BIT_PIN] = out_mode ? ff_q : pin_lvl;
            // Force bits are write-only strobes and read zero
            prdata_d[DACC_BIT_FORCE_COMPARE_B] = 1'b0;
            prdata_d[DACC_BIT_EDGE_POLARITY] = edge_polarity_q;
            prdata_d[3:0] = mode_q;
         end else if (hit_a) begin
            prdata_d[TB_WIDTH-1:0] = cha_q;
         end else if (hit_b) begin
            // Staging copy in off and PWM modes, else the live copy
            prdata_d[TB_WIDTH-1:0] =
               (op == DACC_OP_OFF || op == DACC_OP_PWM) ? chb1_q : chb2_q;
         end
      end
   end

   // ==========================================================
   // Channel behaviour, flag and output flip-flop
   always_comb begin
      mode_d = mode_q;
      edge_polarity_d = edge_polarity_q;
      tbsel_d = tbsel_q;
      wor_d = wor_q;
      flag_d = flag_q;
      flag_seen_d = flag_seen_q;
      cha_d = cha_q;
      chb1_d = chb1_q;
      chb2_d = chb2_q;
      arm_a_d = arm_a_q;
      arm_b_d = arm_b_q;
      first_d = first_q;
      ff_d = ff_q;

      // Mark only a read whose returned word showed the flag set;
      // the flag may rise between staging and answer
      if (rd && hit_ctrl && prdata_q[DACC_BIT_FLAG]) begin
         flag_seen_d = 1'b1;
      end

      // Software writes
      if (wr && hit_ctrl) begin
         mode_d = pwdata[3:0];
         edge_polarity_d = pwdata[DACC_BIT_EDGE_POLARITY];
         tbsel_d = pwdata[DACC_BIT_TBSEL];
         wor_d = pwdata[DACC_BIT_WOR];
         if (!pwdata[DACC_BIT_FLAG] && flag_seen_q) begin
            flag_d = 1'b0;
            flag_seen_d = 1'b0;
         end
         if (pwdata[3:0] != mode_q) begin
            // New mode starts clean; interrupts are software's concern
            arm_a_d = 1'b0;
            arm_b_d = 1'b0;
            first_d = 1'b1;
         end
      end
      if (wr && hit_a) begin
         cha_d = pwdata[TB_WIDTH-1:0];
         arm_a_d = 1'b1;
      end
      if (wr && hit_b) begin
         if (op == DACC_OP_OFF) begin
            chb1_d = pwdata[TB_WIDTH-1:0];
            chb2_d = pwdata[TB_WIDTH-1:0];
         end else if (op == DACC_OP_PWM) begin
            chb1_d = pwdata[TB_WIDTH-1:0];
         end else begin
            chb2_d = pwdata[TB_WIDTH-1:0];
         end
         arm_b_d = 1'b1;
      end

      // Hardware events; placed after the writes so a set wins
      case (op)
         DACC_OP_PWIN: begin
            if (edge_b) begin
               chb1_d = tb;
            end
            if (edge_a) begin
               cha_d = tb;
               chb2_d = chb1_q;
               flag_d = 1'b1;
            end
         end
         DACC_OP_PERIOD: begin
            if (edge_a) begin
               cha_d = tb;
               chb2_d = cha_q;
               first_d = 1'b0;
               if (!first_q) begin
                  flag_d = 1'b1;
               end
            end
         end
         DACC_OP_CAPT: begin
            if (edge_a) begin
               cha_d = tb;
               flag_d = 1'b1;
            end
         end
         DACC_OP_OCB, DACC_OP_COMPARE_FLAG_BOTH_MODE: begin
            if (match_a) begin
               ff_d = ~edge_polarity_q;
               arm_a_d = 1'b0;
               if (op == DACC_OP_COMPARE_FLAG_BOTH_MODE) begin
                  flag_d = 1'b1;
               end
            end
            if (match_b) begin
               ff_d = edge_polarity_q;
               arm_b_d = 1'b0;
               flag_d = 1'b1;
            end
         end
         DACC_OP_PWM: begin
            if (match_a) begin
               ff_d = ~edge_polarity_q;
               chb2_d = chb1_q;
               flag_d = 1'b1;
            end
            if (match_b) begin
               ff_d = edge_polarity_q;
            end
         end
         default: begin
            // Off or unused code: polarity and compares do nothing
            ff_d = ff_q;
         end
      endcase

      // Forces override a compare in the same cycle, flag untouched
      if (wr && hit_ctrl && out_mode) begin
         if (pwdata[DACC_BIT_FORCE_COMPARE_A] && pwdata[DACC_BIT_FORCE_COMPARE_B]) begin
            ff_d = 1'b0;
         end else if (pwdata[DACC_BIT_FORCE_COMPARE_A]) begin
            ff_d = ~edge_polarity_q;
         end else if (pwdata[DACC_BIT_FORCE_COMPARE_B]) begin
            ff_d = edge_polarity_q;
         end
      end
      // In other modes the force bits are simply dropped

      // Only the real off code clears the flag
      if (mode_q == DACC_MODE_OFF) begin
         flag_d = 1'b0;
         flag_seen_d = 1'b0;
      end
   end

   // Pin drive; open-drain releases a high level instead of driving it
   always_comb begin
      pin_out_d = ff_d;
      oe_n_d = 1'b1;
      if (op_of(mode_d) == DACC_OP_OCB || op_of(mode_d) == DACC_OP_COMPARE_FLAG_BOTH_MODE ||
          op_of(mode_d) == DACC_OP_PWM) begin
         oe_n_d = wor_d & ff_d;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= DACC_RST_MODE;
         edge_polarity_q <= 1'b0;
         tbsel_q <= 1'b0;
         wor_q <= 1'b0;
         flag_q <= 1'b0;
         flag_seen_q <= 1'b0;
         cha_q <= DACC_RST_VALUE;
         chb1_q <= DACC_RST_VALUE;
         chb2_q <= DACC_RST_VALUE;
         arm_a_q <= 1'b0;
         arm_b_q <= 1'b0;
         first_q <= 1'b1;
         ff_q <= 1'b0;
         pin_out_q <= 1'b0;
         oe_n_q <= 1'b1;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         edge_polarity_q <= edge_polarity_d;
         tbsel_q <= tbsel_d;
         wor_q <= wor_d;
         flag_q <= flag_d;
         flag_seen_q <= flag_seen_d;
         cha_q <= cha_d;
         chb1_q <= chb1_d;
         chb2_q <= chb2_d;
         arm_a_q <= arm_a_d;
         arm_b_q <= arm_b_d;
         first_q <= first_d;
         ff_q <= ff_d;
         pin_out_q <= pin_out_d;
         oe_n_q <= oe_n_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pin_out = pin_out_q;
   assign pin_oe_n = oe_n_q;

endmodule // dacc_top
`default_nettype wire

/* File: verification/dacc_chk.sv */
// Port checker for the capture/compare block
`timescale 1ns/1ps
`default_nettype none
module dacc_chk
   import dacc_pkg::*;
#(
   parameter int TB_WIDTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [TB_WIDTH-1:0] time_base_a,
   input wire logic [TB_WIDTH-1:0] time_base_b,
   input wire logic pin_in,
   input wire logic pin_out,
   input wire logic pin_oe_n
);
   // ==========
   // Mode shadow, taken only at the edge a write lands
   logic [3:0] mode_q, mode_d;
   logic pol_q, pol_d, wr_ctrl, outm, same;
   assign wr_ctrl = psel && penable && pready && pwrite
      && paddr == DACC_OFS_CTRL;
   assign outm = mode_q[3] || mode_q[3:1] == 3'h2;
   // Force A, force B and both-force checks skip writes that also change mode or polarity
   assign same = pwdata[4:0] == {pol_q, mode_q};
   always_comb begin
      mode_d = wr_ctrl ? pwdata[3:0] : mode_q;
      pol_d = wr_ctrl ? pwdata[DACC_BIT_EDGE_POLARITY] : pol_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 4'h0;
         pol_q <= 1'h0;
      end else begin
         mode_q <= mode_d;
         pol_q <= pol_d;
      end
   end
   // ==========
   // Properties
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence take_s;
      psel && penable && pready;
   endsequence
   ready_pulse_a:
      assert property (setup_s |=> take_s ##1 !pready)
      else $error("ready not a single pulse after setup");
   err_ready_a:
      assert property (pslverr |-> pready)
      else $error("error flag outside a response");
   bad_addr_a:
      assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   upper_zero_a:
      assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
      else $error("upper read bits not zero");
   force_read_a:
      assert property (pready && !pwrite && paddr == DACC_OFS_CTRL
      |-> prdata[6:5] == 2'h0) else $error("force bits read back");
   force_both_a:
      assert property (wr_ctrl && outm && same && pwdata[6:5] == 2'h3
      |=> !pin_out) else $error("both forces did not clear output");
   force_a_a:
      assert property (wr_ctrl && outm && same && pwdata[6:5] == 2'h2
      |=> pin_out == !pol_q) else $error("force A wrong level");
   force_b_a:
      assert property (wr_ctrl && outm && same && pwdata[6:5] == 2'h1
      |=> pin_out == pol_q) else $error("force B wrong level");
   force_ign_a:
      assert property (wr_ctrl && !outm && pwdata[3:0] == mode_q
      |=> $stable(pin_out)) else $error("force acted in idle mode");
   idle_release_a:
      assert property (!outm ##1 !outm |-> pin_oe_n)
      else $error("pin driven outside output modes");
endmodule // dacc_chk

bind dacc_top dacc_chk #(.TB_WIDTH(TB_WIDTH)) i_chk (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .time_base_a, .time_base_b, .pin_in, .pin_out, .pin_oe_n);
`default_nettype wire

/* File: verification/dacc_far.sv */
// Far side model: time base buses and the pin
`timescale 1ns/1ps
`default_nettype none
module dacc_far (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic pin_level,
   input wire logic pin_out,
   input wire logic pin_oe_n,
   output logic [15:0] time_base_a,
   output logic [15:0] time_base_b,
   output logic pin_in
);
   // ==========
   // Bus A counts up, bus B down, so a wrong bus never matches
   logic [15:0] a_q, a_d, b_q, b_d;
   always_comb begin
      a_d = load ? load_val : a_q + {15'h0, run};
      b_d = load ? ~load_val : b_q - {15'h0, run};
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_q <= 16'h0;
         b_q <= 16'hFFFF;
      end else begin
         a_q <= a_d;
         b_q <= b_d;
      end
   end
   assign time_base_a = a_q;
   assign time_base_b = b_q;
   // Driven pin wins over the outside level
   assign pin_in = pin_oe_n ? pin_level : pin_out;
endmodule // dacc_far
`default_nettype wire

/* File: verification/dacc_top_tb.sv */
// Self-checking bench for the capture/compare block
`timescale 1ns/1ps
`default_nettype none
module dacc_top_tb
   import dacc_pkg::*;
;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic run = 1'h0;
   logic load = 1'h0;
   logic lvl = 1'h0;
   logic [15:0] ld_val = 16'h0;
   logic [31:0] prdata;
   logic pready, pslverr, pin_out, pin_oe_n, pin_in;
   logic [15:0] tb_a, tb_b, v1, v2, ea, eb;
   logic [31:0] exp_q[$];
   int err_total = 0;
   int n_tests = 0;
   int seed = 32'h64B8B47F;
   // Control write data and expected pin, packed {data, pin}
   logic [8:0] ftab [11] = '{9'h080, 9'h08C, 9'h086, 9'h008, 9'h089,
      9'h048, 9'h089, 9'h0C8, 9'h028, 9'h069, 9'h0A8};
   // Compare resolution of PWM modes 1000 to 1111
   int res_tab [8] = '{16, 15, 14, 13, 12, 11, 9, 7};
   always #12.5 pclk = ~pclk;
   dacc_top #(.TB_WIDTH(16)) i_dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .time_base_a(tb_a), .time_base_b(tb_b), .pin_in, .pin_out,
      .pin_oe_n);
   dacc_far i_far (.pclk, .presetn, .run, .load, .load_val(ld_val),
      .pin_level(lvl), .pin_out, .pin_oe_n, .time_base_a(tb_a),
      .time_base_b(tb_b), .pin_in);
   // ==========
   // Checking and closing
   task automatic chk(input string nm, input logic [31:0] seen,
         input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ==========
   // Drivers; request held until ready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'h0, a, 32'h0);
   endtask
   task automatic tbset(input logic [15:0] v, input logic r);
      @(posedge pclk);
      load <= 1'h1;
      ld_val <= v;
      run <= r;
      @(posedge pclk);
      load <= 1'h0;
   endtask
   // Time base frozen so the captured value is exact
   task automatic edge_at(input logic [15:0] v, input logic l);
      tbset(v, 1'h0);
      repeat (2) @(posedge pclk);
      lvl <= l;
      repeat (4) @(posedge pclk);
   endtask
   task automatic wait_pin(input logic v);
      int i;
      i = 0;
      do begin
         @(negedge pclk);
         i++;
      end while (pin_out !== v && i < 3000);
      chk("pin level", {31'h0, pin_out}, {31'h0, v});
   endtask
   // Read monitor pairs each answer with the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'h1 && !pwrite) begin
         chk("read data", prdata, exp_q.pop_front());
      end
   end
   // Hang guard
   initial begin
      repeat (30000) @(posedge pclk);
      err_total++;
      tally_and_finish();
   end
   // ==========
   // Scenarios; mode changes made with no interrupt logic present
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      rd(DACC_OFS_CTRL, 32'h0);
      rd(DACC_OFS_CHA, 32'h0);
      rd(8'h0C, 32'h0);
      v1 = 16'($random(seed));
      apb(1'h1, DACC_OFS_CHA, {16'h0, v1});
      rd(DACC_OFS_CHA, {16'h0, v1});
      $display("reset and preload done");
      foreach (ftab[i]) begin
         apb(1'h1, DACC_OFS_CTRL, {24'h0, ftab[i][8:1]});
         @(negedge pclk);
         // Pad follows the driven level, or the idle low outside
         chk("pin", 32'(pin_out), 32'(ftab[i][0]));
         chk("pad", 32'(pin_in), 32'(ftab[i][0]));
      end
      $display("force test done");
      // B-only flag first on bus A, then A-or-B flag on bus B
      for (int s = 0; s < 2; s++) begin
         apb(1'h1, DACC_OFS_CTRL, s ? 32'h105 : 32'h4);
         tbset(16'h0, 1'h1);
         ea = s ? 16'hFFC0 : 16'h0040;
         eb = s ? ea - 16'h40 : ea + 16'h40;
         apb(1'h1, DACC_OFS_CHA, {16'h0, ea});
         wait_pin(1'h1);
         v2 = s ? tb_b : tb_a;
         v1 = s ? ea - 16'h1 : ea + 16'h1;
         chk("tb at A", {16'h0, v2}, {16'h0, v1});
         rd(DACC_OFS_CTRL, s ? 32'h8185 : 32'h84);
         apb(1'h1, DACC_OFS_CHB, {16'h0, eb});
         wait_pin(1'h0);
         v2 = s ? tb_b : tb_a;
         v1 = s ? eb - 16'h1 : eb + 16'h1;
         chk("tb at B", {16'h0, v2}, {16'h0, v1});
         rd(DACC_OFS_CTRL, s ? 32'h8105 : 32'h8004);
      end
      $display("compare test done");
      for (int m = 1; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            apb(1'h1, DACC_OFS_CTRL, 32'h0);
            apb(1'h1, DACC_OFS_CTRL, m | (p << 4));
            v1 = 16'($random(seed));
            v2 = 16'($random(seed));
            edge_at(v1, 1'h1);
            edge_at(v2, 1'h0);
            v1 = p ? v2 : v1;
            rd(DACC_OFS_CHA, {16'h0, v1});
            ea = {m != 2, 10'h0, p[0], m[3:0]};
            rd(DACC_OFS_CTRL, {16'h0, ea});
         end
      end
      $display("capture test done");
      // Every PWM code; bits above the resolution must not delay a match
      for (int k = 0; k < 8; k++) begin
         ea = (16'hFFFF << res_tab[k]) | 16'h0005;
         eb = (16'hFFFF << res_tab[k]) | 16'h0040;
         apb(1'h1, DACC_OFS_CTRL, 32'h0);
         tbset(16'h0, 1'h0);
         apb(1'h1, DACC_OFS_CHB, {16'h0, eb});
         apb(1'h1, DACC_OFS_CHA, {16'h0, ea});
         apb(1'h1, DACC_OFS_CTRL, 32'(8 + k));
         tbset(16'h0, 1'h1);
         wait_pin(1'h1);
         chk("pwm lead", {16'h0, tb_a}, 32'h6);
         wait_pin(1'h0);
         chk("pwm trail", {16'h0, tb_a}, 32'h41);
      end
      $display("pwm test done");
      tally_and_finish();
   end
endmodule // dacc_top_tb
`default_nettype wire
